// ===== bench/opc_regs_checker.sv
// port checks on the output loop register bank
`timescale 1ns/1ps
module opc_regs_checker
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // loop status inputs
   input wire logic loop_lock_raw,
   input wire logic input_loop_ref_ok,
   // outputs under watch
   input wire logic [7:0] cp_current_code,
   input wire logic [19:0] cp_current_na,
   input wire logic pump_tristate,
   input wire logic pump_up,
   input wire logic pump_down,
   input wire logic pump_normal,
   input wire logic [1:0] fb_count_fine,
   input wire logic [5:0] fb_count_coarse,
   input wire logic [7:0] fb_ratio,
   input wire logic fb_ratio_ok,
   input wire logic lock_det_pwrdn,
   input wire logic loop_locked,
   input wire logic dist_sync_hold,
   input wire logic ref_valid,
   input wire logic vco_cal_start,
   input wire logic vco_cal_reset
);
   // legal divider settings, judged apart from the design's flag
   wire logic fb_legal = (fb_count_coarse >= 6'h07)
      || (fb_count_coarse == 6'h04 && !fb_count_fine[1])
      || (fb_count_coarse inside {6'h05, 6'h06} && fb_count_fine != 2'h3);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ****************************************************************
   // port relations
   // ****************************************************************
   a_cp_scale:
      assert property ($past(aresetn) |->
         cp_current_na == 20'h00DAC * 20'($past(cp_current_code)))
      else $error("pump current estimate off");
   a_fb_ratio:
      assert property ($past(aresetn) |-> fb_ratio == 8'(4 * fb_count_coarse + fb_count_fine)
         && fb_ratio_ok == $past(fb_legal))
      else $error("divider ratio or legality off");
   a_lock_gate:
      assert property ($past(aresetn) |-> loop_locked == ($past(loop_lock_raw) && !$past(lock_det_pwrdn)))
      else $error("lock flag not gated");
   a_pump_onehot:
      assert property ($onehot({pump_tristate, pump_up, pump_down, pump_normal}))
      else $error("pump mode not one-hot");
   a_hold_release:
      assert property (loop_locked |-> ##[1:3] !dist_sync_hold)
      else $error("distribution not released");
   a_ref_ok:
      assert property ($past(aresetn) && $past(input_loop_ref_ok) |-> ref_valid)
      else $error("reference not valid");
   a_cal_launch:
      assert property ($fell(vco_cal_reset) |=> vco_cal_start)
      else $error("calibration not launched");
   a_cal_edge:
      assert property (vco_cal_start |-> $past(vco_cal_reset, 2) && !vco_cal_reset ##1 !vco_cal_start)
      else $error("launch without a rising bit");
   // main scenarios reached
   c_cal: cover property (vco_cal_start);
   c_rel: cover property ($fell(dist_sync_hold));
   c_pd: cover property (lock_det_pwrdn && loop_lock_raw);
endmodule
bind opc_output_pll_regs opc_regs_checker u_chk (.*);

// ===== bench/tb_opc_output_pll_regs.sv
// self-checking bench of the output loop registers
`timescale 1ns/1ps
module tb_opc_output_pll_regs
   import opc_pkg::*;
;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [11:0] s_axil_awaddr = 12'h000, s_axil_araddr = 12'h000;
   logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
   logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
   logic s_axil_arvalid = 1'h0, s_axil_rready = 1'h0;
   logic loop_lock_raw = 1'h0, input_loop_ref_ok = 1'h0, vco_cal_done = 1'h0;
   logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
   logic [1:0] s_axil_bresp, s_axil_rresp, fb_count_fine, abl_period;
   logic [7:0] cp_current_code, fb_ratio, d, fbv [8], fb_legal = 8'h65;
   logic [19:0] cp_current_na;
   logic [5:0] fb_count_coarse;
   logic pump_tristate, pump_up, pump_down, pump_normal, fb_ratio_ok, lock_det_pwrdn, loop_locked;
   logic ref_doubler_en, dist_sync_hold, ref_valid, vco_midscale, vco_cal_start, vco_cal_reset;
   logic vco_cal_busy;
   logic [31:0] rnd = 32'h53DF3964;
   logic [33:0] rq [$];
   logic [1:0] bq [$];
   int miscompares = 0, checks_done = 0, cyc = 0, ncal = 0;

   opc_output_pll_regs u_dut (.*, .s_axil_awprot(3'h0), .s_axil_arprot(3'h0), .s_axil_wstrb(4'hF));

   always #5 aclk = ~aclk;

   // ****************************************************************
   // reporting and bus tasks
   // ****************************************************************
   task finish_test;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task cmp_r(input logic [33:0] g, input logic [33:0] e);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task cmp_b(input logic [1:0] g, input logic [1:0] e);
      cmp_r(34'(g), 34'(e));
   endtask
   task cmp_o(input logic [19:0] g, input logic [19:0] e);
      cmp_r(34'(g), 34'(e));
   endtask
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // readies are sampled mid-cycle, settled for the coming edge
   task wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] r);
      logic pa, pw, ta, tw;
      pa = 1'h1;
      pw = 1'h1;
      @(posedge aclk);
      bq.push_back(r);
      s_axil_awaddr <= a;
      s_axil_wdata <= {rnd[31:8], v};
      s_axil_awvalid <= 1'h1;
      s_axil_wvalid <= 1'h1;
      s_axil_bready <= 1'h1;
      while (pa || pw)
      begin
         @(negedge aclk);
         ta = pa & s_axil_awready;
         tw = pw & s_axil_wready;
         @(posedge aclk);
         if (ta) s_axil_awvalid <= 1'h0;
         if (tw) s_axil_wvalid <= 1'h0;
         pa = pa & !ta;
         pw = pw & !tw;
      end
      do @(negedge aclk); while (!s_axil_bvalid);
      @(posedge aclk);
      s_axil_bready <= 1'h0;
   endtask
   task rd(input logic [11:0] a, input logic [33:0] e);
      @(posedge aclk);
      rq.push_back(e);
      s_axil_araddr <= a;
      s_axil_arvalid <= 1'h1;
      s_axil_rready <= 1'h1;
      do @(negedge aclk); while (!s_axil_arready);
      @(posedge aclk);
      s_axil_arvalid <= 1'h0;
      do @(negedge aclk); while (!s_axil_rvalid);
      @(posedge aclk);
      s_axil_rready <= 1'h0;
   endtask
   task wrd(input logic [11:0] a, input logic [7:0] v, input logic [7:0] rb);
      wr(a, v, OPC_RESP_OKAY);
      rd(a, {26'h0, rb});
   endtask
   task settle;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask

   // answer watcher, pulse counter and hang limit
   always @(negedge aclk)
   begin
      if (s_axil_rvalid && s_axil_rready) cmp_r({s_axil_rresp, s_axil_rdata}, rq.pop_front());
      if (s_axil_bvalid && s_axil_bready) cmp_b(s_axil_bresp, bq.pop_front());
      if (vco_cal_start === 1'h1) ncal++;
      cyc++;
      if (cyc == 5000)
      begin
         miscompares++;
         finish_test;
      end
   end

   // main sequence
   initial
   begin
      fbv = '{8'h44, 8'h84, 8'h85, 8'hC5, 8'hC6, 8'hC7, 8'hFF, 8'h03};
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      rd(OPC_ADDR_CP_CUR, {26'h0, OPC_CP_CUR_RST});
      rd(OPC_ADDR_FB_DIV, {26'h0, OPC_FB_DIV_RST});
      rd(OPC_ADDR_LOOP_CTL, {26'h0, 8'h0B});
      rd(OPC_ADDR_VCO_CTL, 34'h0);
      cmp_o(20'({pump_normal, abl_period, dist_sync_hold}), 20'hD);
      wrd(OPC_ADDR_VCO_CTL, 8'h10, 8'h10);
      settle;
      cmp_o(20'({dist_sync_hold, ref_valid}), 20'h0);
      wrd(OPC_ADDR_VCO_CTL, 8'h0C, 8'h0C);
      settle;
      cmp_o(20'({dist_sync_hold, ref_valid, vco_midscale}), 20'h7);
      wrd(OPC_ADDR_VCO_CTL, 8'h00, 8'h00);
      input_loop_ref_ok <= 1'h1;
      settle;
      cmp_o(20'({ref_valid, vco_midscale}), 20'h2);
      for (int i = 0; i < 3; i++)
      begin
         rnd = lfsr(rnd);
         d = (i == 0) ? 8'hFF : rnd[7:0];
         wrd(OPC_ADDR_CP_CUR, d, d);
         settle;
         cmp_o(cp_current_na, 20'h00DAC * {12'h000, d});
      end
      wrd(OPC_ADDR_LOOP_CTL, 8'hFF, 8'hBF);
      loop_lock_raw <= 1'h1;
      settle;
      cmp_o(20'({lock_det_pwrdn, loop_locked, ref_doubler_en, abl_period, dist_sync_hold}), 20'h2F);
      for (int i = 0; i < 4; i++)
      begin
         wrd(OPC_ADDR_LOOP_CTL, {4'h1, 2'(i), 2'(i)}, {4'h1, 2'(i), 2'(i)});
         settle;
         cmp_o(20'({abl_period, pump_normal, pump_down, pump_up, pump_tristate}), 20'({2'(i), 4'h1 << i}));
      end
      loop_lock_raw <= 1'h0;
      wrd(OPC_ADDR_LOOP_CTL, 8'h03, 8'h03);
      settle;
      cmp_o(20'({abl_period, dist_sync_hold}), 20'h4);
      foreach (fbv[i])
      begin
         wrd(OPC_ADDR_FB_DIV, fbv[i], fbv[i]);
         settle;
         cmp_o(20'({fb_ratio_ok, fb_ratio, fb_count_fine, fb_count_coarse}),
            20'({fb_legal[i], fbv[i][5:0], fbv[i][7:6], fbv[i][7:6], fbv[i][5:0]}));
      end
      wrd(OPC_ADDR_VCO_CTL, 8'h02, 8'h02);
      wrd(OPC_ADDR_VCO_CTL, 8'h02, 8'h02);
      settle;
      cmp_o(20'({vco_cal_busy, vco_cal_reset, 4'(ncal)}), 20'h21);
      vco_cal_done <= 1'h1;
      wrd(OPC_ADDR_VCO_CTL, 8'h00, 8'h00);
      vco_cal_done <= 1'h0;
      wrd(OPC_ADDR_VCO_CTL, 8'h02, 8'h02);
      settle;
      cmp_o(20'(ncal), 20'h2);
      rd(12'h000, {OPC_RESP_SLVERR, 32'h0});
      wr(OPC_ADDR_STATUS, 8'h55, OPC_RESP_SLVERR);
      finish_test;
   end
endmodule

// ===== hdl/opc_axil_slave.sv
// axi4-lite front end of the output loop registers
`timescale 1ns/1ps
module opc_axil_slave
   import opc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic [OPC_ADDR_W-1:0] s_axil_awaddr,
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   // read channels
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   // register file side
   output logic wr_fire,
   output logic [OPC_ADDR_W-1:0] wr_addr,
   output logic [7:0] wr_data,
   output logic wr_lane0,
   input wire logic wr_ok,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [OPC_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
   logic [7:0] w_data_r, w_data_nxt;
   logic w_lane_r, w_lane_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // address and data wait for each other, in either order
   assign s_axil_awready = ~aw_full_r & ~bvalid_r;
   assign s_axil_wready = ~w_full_r & ~bvalid_r;
   assign s_axil_arready = ~rvalid_r;
   assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;
   assign wr_addr = aw_addr_r;
   assign wr_data = w_data_r;
   assign wr_lane0 = w_lane_r;
   assign s_axil_bvalid = bvalid_r;
   assign s_axil_bresp = bresp_r;
   assign s_axil_rvalid = rvalid_r;
   assign s_axil_rresp = rresp_r;
   assign s_axil_rdata = rdata_r;

   // next state of both channel pairs
   always_comb
   begin
      aw_full_nxt = aw_full_r;
      aw_addr_nxt = aw_addr_r;
      w_full_nxt = w_full_r;
      w_data_nxt = w_data_r;
      w_lane_nxt = w_lane_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (s_axil_awvalid && s_axil_awready)
      begin
         aw_full_nxt = 1'b1;
         aw_addr_nxt = s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready)
      begin
         w_full_nxt = 1'b1;
         w_data_nxt = s_axil_wdata[7:0]; // upper lanes hold nothing
         w_lane_nxt = s_axil_wstrb[0];
      end
      if (wr_fire)
      begin
         aw_full_nxt = 1'b0;
         w_full_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = wr_ok ? OPC_RESP_OKAY : OPC_RESP_SLVERR;
      end
      else if (bvalid_r && s_axil_bready)
      begin
         bvalid_nxt = 1'b0;
      end
      if (s_axil_arvalid && s_axil_arready)
      begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_data;
         rresp_nxt = rd_ok ? OPC_RESP_OKAY : OPC_RESP_SLVERR;
      end
      else if (rvalid_r && s_axil_rready)
      begin
         rvalid_nxt = 1'b0;
      end
   end

   // channel registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         aw_addr_r <= '0;
         w_full_r <= 1'b0;
         w_data_r <= 8'h00;
         w_lane_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= OPC_RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= OPC_RESP_OKAY;
         rdata_r <= 32'h00000000;
      end
      else
      begin
         aw_full_r <= aw_full_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_full_r <= w_full_nxt;
         w_data_r <= w_data_nxt;
         w_lane_r <= w_lane_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
      end
   end
endmodule

// ===== hdl/opc_output_pll_regs.sv
// top of the output loop register bank
//
// Notes on behaviour
// - 8-bit pump current code, ~3.5 uA per step, ~900 uA full scale.
// - divider bits 7:6 fine, 5:0 coarse, ratio four coarse plus fine, limited.
// - control bit 7 high powers down the loop lock detector.
// - control bit 5 high doubles the loop reference frequency.
// - control bit 4 low forces antibacklash high; high uses the field.
// - field 3:2 picks antibacklash min, low, high, max; starts high.
// - pump mode 1:0 is tristate, up, down, normal; defaults normal.
// - override low holds distribution until first lock, then releases.
// - vco bit 4 high ignores lock state and releases distribution.
// - vco bit 3 low: reference validity from the input loop indicator.
// - vco bit 3 high treats the reference as valid regardless.
// - vco bit 2 high forces vco control voltage to midscale.
// - writing 1 to vco bit 1 starts calibration; software clears it.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module opc_output_pll_regs
   import opc_pkg::*;
#(
   parameter logic [7:0] CP_CUR_RST = OPC_CP_CUR_RST,
   parameter logic [7:0] FB_DIV_RST = OPC_FB_DIV_RST
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [OPC_ADDR_W-1:0] s_axil_awaddr,
   input wire logic [2:0] s_axil_awprot,
   input wire logic s_axil_awvalid,
   output logic s_axil_awready,
   input wire logic [31:0] s_axil_wdata,
   input wire logic [3:0] s_axil_wstrb,
   input wire logic s_axil_wvalid,
   output logic s_axil_wready,
   // axi4-lite write response
   output logic [1:0] s_axil_bresp,
   output logic s_axil_bvalid,
   input wire logic s_axil_bready,
   // axi4-lite read
   input wire logic [OPC_ADDR_W-1:0] s_axil_araddr,
   input wire logic [2:0] s_axil_arprot,
   input wire logic s_axil_arvalid,
   output logic s_axil_arready,
   output logic [31:0] s_axil_rdata,
   output logic [1:0] s_axil_rresp,
   output logic s_axil_rvalid,
   input wire logic s_axil_rready,
   // status from the analog loop
   input wire logic loop_lock_raw,
   input wire logic input_loop_ref_ok,
   input wire logic vco_cal_done,
   // charge pump
   output logic [7:0] cp_current_code,
   output logic [19:0] cp_current_na,
   output logic pump_tristate,
   output logic pump_up,
   output logic pump_down,
   output logic pump_normal,
   // feedback divider
   output logic [1:0] fb_count_fine,
   output logic [5:0] fb_count_coarse,
   output logic [7:0] fb_ratio,
   output logic fb_ratio_ok,
   // loop control
   output logic lock_det_pwrdn,
   output logic loop_locked,
   output logic ref_doubler_en,
   output logic [1:0] abl_period,
   // distribution and vco
   output logic dist_sync_hold,
   output logic ref_valid,
   output logic vco_midscale,
   output logic vco_cal_start,
   output logic vco_cal_reset,
   output logic vco_cal_busy
);
   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [7:0] cp_cur_r, cp_cur_nxt, fb_div_r, fb_div_nxt;
   logic [7:0] loop_ctl_r, loop_ctl_nxt, vco_ctl_r, vco_ctl_nxt;
   logic wr_fire, wr_lane0, wr_ok, rd_ok;
   logic [OPC_ADDR_W-1:0] wr_addr;
   logic [7:0] wr_data;
   logic [31:0] rd_data;
   logic dist_released, dist_hold, cal_start, cal_busy;
   logic [19:0] cp_na_r, cp_na_nxt;
   logic [3:0] pump_r, pump_nxt;
   logic [1:0] abl_r, abl_nxt;
   logic ratio_ok_r, ratio_ok_nxt;
   logic locked_r, locked_nxt, ref_valid_r, ref_valid_nxt;

   // legal fine range per coarse count
   function automatic logic fb_ok(input logic [7:0] v);
      logic [1:0] fine;
      logic [5:0] coarse;
      fine = v[7:OPC_FB_A_LSB];
      coarse = v[OPC_FB_A_LSB-1:0];
      if (coarse < OPC_B_MIN)
      begin
         fb_ok = 1'b0;
      end
      else if (coarse == OPC_B_MIN)
      begin
         fb_ok = (fine <= 2'h1);
      end
      else if (coarse < OPC_B_FREE)
      begin
         fb_ok = (fine <= 2'h2);
      end
      else
      begin
         fb_ok = 1'b1;
      end
   endfunction

   // ****************************************************************
   // bus front end
   // ****************************************************************
   opc_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axil_awaddr(s_axil_awaddr),
      .s_axil_awvalid(s_axil_awvalid),
      .s_axil_awready(s_axil_awready),
      .s_axil_wdata(s_axil_wdata),
      .s_axil_wstrb(s_axil_wstrb),
      .s_axil_wvalid(s_axil_wvalid),
      .s_axil_wready(s_axil_wready),
      .s_axil_bresp(s_axil_bresp),
      .s_axil_bvalid(s_axil_bvalid),
      .s_axil_bready(s_axil_bready),
      .s_axil_arvalid(s_axil_arvalid),
      .s_axil_arready(s_axil_arready),
      .s_axil_rdata(s_axil_rdata),
      .s_axil_rresp(s_axil_rresp),
      .s_axil_rvalid(s_axil_rvalid),
      .s_axil_rready(s_axil_rready),
      .wr_fire(wr_fire),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_lane0(wr_lane0),
      .wr_ok(wr_ok),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // ****************************************************************
   // register file
   // ****************************************************************
   // status is read only, so writes to it are refused
   assign wr_ok = (wr_addr == OPC_ADDR_CP_CUR) || (wr_addr == OPC_ADDR_FB_DIV) ||
                  (wr_addr == OPC_ADDR_LOOP_CTL) || (wr_addr == OPC_ADDR_VCO_CTL);

   // write decode; lane 0 off still completes, changing nothing
   always_comb
   begin
      cp_cur_nxt = cp_cur_r;
      fb_div_nxt = fb_div_r;
      loop_ctl_nxt = loop_ctl_r;
      vco_ctl_nxt = vco_ctl_r;
      if (wr_fire && wr_lane0)
      begin
         case (wr_addr)
            OPC_ADDR_CP_CUR: cp_cur_nxt = wr_data;
            OPC_ADDR_FB_DIV: fb_div_nxt = wr_data;
            // bit 6 stays zero whatever software writes
            OPC_ADDR_LOOP_CTL: loop_ctl_nxt = wr_data & OPC_LOOP_CTL_WMASK;
            // reserved vco bits stay zero; calibrate does not self clear
            OPC_ADDR_VCO_CTL: vco_ctl_nxt = wr_data & OPC_VCO_CTL_WMASK;
            default: cp_cur_nxt = cp_cur_r;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cp_cur_r <= CP_CUR_RST;
         fb_div_r <= FB_DIV_RST;
         loop_ctl_r <= OPC_LOOP_CTL_RST;
         vco_ctl_r <= OPC_VCO_CTL_RST;
      end
      else
      begin
         cp_cur_r <= cp_cur_nxt;
         fb_div_r <= fb_div_nxt;
         loop_ctl_r <= loop_ctl_nxt;
         vco_ctl_r <= vco_ctl_nxt;
      end
   end

   // read mux on the live read address, sampled by the front end
   always_comb
   begin
      rd_data = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axil_araddr)
         OPC_ADDR_CP_CUR: rd_data[7:0] = cp_cur_r;
         OPC_ADDR_FB_DIV: rd_data[7:0] = fb_div_r;
         OPC_ADDR_LOOP_CTL: rd_data[7:0] = loop_ctl_r;
         OPC_ADDR_VCO_CTL: rd_data[7:0] = vco_ctl_r;
         OPC_ADDR_STATUS: rd_data[5:0] = {cal_busy, ratio_ok_r, ref_valid_r,
                                          locked_r, dist_hold, dist_released};
         default: rd_ok = 1'b0;
      endcase
   end

   // ****************************************************************
   // sync release and calibration
   // ****************************************************************
   opc_sync_cal u_seq (
      .aclk(aclk),
      .aresetn(aresetn),
      .loop_locked(locked_r),
      .sync_force(vco_ctl_r[OPC_VCO_SYNC_FORCE]),
      .cal_bit(vco_ctl_r[OPC_VCO_CAL]),
      .cal_done(vco_cal_done),
      .dist_released(dist_released),
      .dist_hold(dist_hold),
      .cal_start(cal_start),
      .cal_busy(cal_busy)
   );

   // ****************************************************************
   // decoded controls toward the analog loop
   // ****************************************************************
   always_comb
   begin
      // estimate in nanoamps: code times step
      cp_na_nxt = 20'(cp_cur_r) * OPC_CP_STEP_NA;
      case (loop_ctl_r[OPC_CTL_CPM_LSB +: 2])
         OPC_CPM_TRISTATE: pump_nxt = 4'h1;
         OPC_CPM_UP: pump_nxt = 4'h2;
         OPC_CPM_DOWN: pump_nxt = 4'h4;
         OPC_CPM_NORMAL: pump_nxt = 4'h8;
         default: pump_nxt = 4'h8;
      endcase
      // forced high period cuts the usable pfd rate, hence the software bit
      if (loop_ctl_r[OPC_CTL_ABL_SW])
      begin
         abl_nxt = loop_ctl_r[OPC_CTL_ABL_LSB +: 2];
      end
      else
      begin
         abl_nxt = OPC_ABL_HIGH;
      end
      ratio_ok_nxt = fb_ok(fb_div_r);
      // a powered down detector never reports lock
      locked_nxt = loop_lock_raw & ~loop_ctl_r[OPC_CTL_LD_PD];
      if (vco_ctl_r[OPC_VCO_REF_VALID])
      begin
         ref_valid_nxt = 1'b1;
      end
      else
      begin
         ref_valid_nxt = input_loop_ref_ok;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cp_na_r <= 20'h00000;
         pump_r <= 4'h8;
         abl_r <= OPC_ABL_HIGH;
         ratio_ok_r <= 1'b0;
         locked_r <= 1'b0;
         ref_valid_r <= 1'b0;
      end
      else
      begin
         cp_na_r <= cp_na_nxt;
         pump_r <= pump_nxt;
         abl_r <= abl_nxt;
         ratio_ok_r <= ratio_ok_nxt;
         locked_r <= locked_nxt;
         ref_valid_r <= ref_valid_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign cp_current_code = cp_cur_r;
   assign cp_current_na = cp_na_r;
   assign pump_tristate = pump_r[0];
   assign pump_up = pump_r[1];
   assign pump_down = pump_r[2];
   assign pump_normal = pump_r[3];
   assign fb_count_fine = fb_div_r[7:OPC_FB_A_LSB];
   assign fb_count_coarse = fb_div_r[OPC_FB_A_LSB-1:0];
   // four coarse plus fine puts coarse above the two fine bits
   assign fb_ratio = {fb_count_coarse, fb_count_fine};
   assign fb_ratio_ok = ratio_ok_r;
   assign lock_det_pwrdn = loop_ctl_r[OPC_CTL_LD_PD];
   assign loop_locked = locked_r;
   assign ref_doubler_en = loop_ctl_r[OPC_CTL_DBL];
   assign abl_period = abl_r;
   assign dist_sync_hold = dist_hold;
   assign ref_valid = ref_valid_r;
   assign vco_midscale = vco_ctl_r[OPC_VCO_MID];
   assign vco_cal_start = cal_start;
   assign vco_cal_reset = ~vco_ctl_r[OPC_VCO_CAL];
   assign vco_cal_busy = cal_busy;
endmodule

// ===== hdl/opc_pkg.sv
// constants of the output loop register bank
package opc_pkg;
   // ****************************************************************
   // register indices and byte addresses
   // ****************************************************************
   localparam int OPC_ADDR_W = 12;
   localparam logic [7:0] OPC_IDX_CP_CUR = 8'hF0;
   localparam logic [7:0] OPC_IDX_FB_DIV = 8'hF1;
   localparam logic [7:0] OPC_IDX_LOOP_CTL = 8'hF2;
   localparam logic [7:0] OPC_IDX_VCO_CTL = 8'hF3;
   localparam logic [7:0] OPC_IDX_STATUS = 8'hF8;
   localparam logic [11:0] OPC_ADDR_CP_CUR = {2'h0, OPC_IDX_CP_CUR, 2'h0};
   localparam logic [11:0] OPC_ADDR_FB_DIV = {2'h0, OPC_IDX_FB_DIV, 2'h0};
   localparam logic [11:0] OPC_ADDR_LOOP_CTL = {2'h0, OPC_IDX_LOOP_CTL, 2'h0};
   localparam logic [11:0] OPC_ADDR_VCO_CTL = {2'h0, OPC_IDX_VCO_CTL, 2'h0};
   localparam logic [11:0] OPC_ADDR_STATUS = {2'h0, OPC_IDX_STATUS, 2'h0};
   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int OPC_CTL_LD_PD = 7;
   localparam int OPC_CTL_DBL = 5;
   localparam int OPC_CTL_ABL_SW = 4;
   localparam int OPC_CTL_ABL_LSB = 2;
   localparam int OPC_CTL_CPM_LSB = 0;
   localparam int OPC_VCO_SYNC_FORCE = 4;
   localparam int OPC_VCO_REF_VALID = 3;
   localparam int OPC_VCO_MID = 2;
   localparam int OPC_VCO_CAL = 1;
   localparam int OPC_FB_A_LSB = 6;
   // ****************************************************************
   // reset values and writable masks
   // ****************************************************************
   localparam logic [7:0] OPC_CP_CUR_RST = 8'h00;
   localparam logic [7:0] OPC_FB_DIV_RST = 8'h1C;
   localparam logic [7:0] OPC_LOOP_CTL_RST = 8'h0B;
   localparam logic [7:0] OPC_VCO_CTL_RST = 8'h00;
   localparam logic [7:0] OPC_LOOP_CTL_WMASK = 8'hBF;
   localparam logic [7:0] OPC_VCO_CTL_WMASK = 8'h1E;
   // ****************************************************************
   // encodings and limits
   // ****************************************************************
   localparam logic [1:0] OPC_ABL_HIGH = 2'h2;
   localparam logic [1:0] OPC_CPM_TRISTATE = 2'h0;
   localparam logic [1:0] OPC_CPM_UP = 2'h1;
   localparam logic [1:0] OPC_CPM_DOWN = 2'h2;
   localparam logic [1:0] OPC_CPM_NORMAL = 2'h3;
   localparam logic [19:0] OPC_CP_STEP_NA = 20'h00DAC;
   localparam logic [5:0] OPC_B_MIN = 6'h04;
   localparam logic [5:0] OPC_B_FREE = 6'h07;
   localparam logic [1:0] OPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] OPC_RESP_SLVERR = 2'h2;
endpackage

// ===== hdl/opc_sync_cal.sv
// sync release sequencer and calibration launcher
`timescale 1ns/1ps
module opc_sync_cal
   import opc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // controls and loop status
   input wire logic loop_locked,
   input wire logic sync_force,
   input wire logic cal_bit,
   input wire logic cal_done,
   // results
   output logic dist_released,
   output logic dist_hold,
   output logic cal_start,
   output logic cal_busy
);
   typedef enum logic {OPC_SYNC_HOLD, OPC_SYNC_FREE} opc_sync_e;
   opc_sync_e sync_r, sync_nxt;
   logic cal_prev_r, cal_prev_nxt, cal_start_r, cal_start_nxt;
   logic cal_busy_r, cal_busy_nxt, hold_r, hold_nxt;

   // held until the first lock, then free until reset
   always_comb
   begin
      sync_nxt = sync_r;
      case (sync_r)
         OPC_SYNC_HOLD:
         begin
            if (loop_locked)
            begin
               sync_nxt = OPC_SYNC_FREE;
            end
         end
         OPC_SYNC_FREE: sync_nxt = OPC_SYNC_FREE;
         default: sync_nxt = OPC_SYNC_HOLD;
      endcase
      // the override releases at any lock state
      hold_nxt = (sync_nxt == OPC_SYNC_HOLD) & ~sync_force;
   end

   // only a rising calibrate bit launches a run
   always_comb
   begin
      cal_prev_nxt = cal_bit;
      cal_start_nxt = cal_bit & ~cal_prev_r;
      cal_busy_nxt = cal_busy_r;
      if (cal_done || !cal_bit)
      begin
         cal_busy_nxt = 1'b0;
      end
      if (cal_start_nxt)
      begin
         cal_busy_nxt = 1'b1; // a start beats a same-cycle done
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync_r <= OPC_SYNC_HOLD;
         hold_r <= 1'b1;
         cal_prev_r <= 1'b0;
         cal_start_r <= 1'b0;
         cal_busy_r <= 1'b0;
      end
      else
      begin
         sync_r <= sync_nxt;
         hold_r <= hold_nxt;
         cal_prev_r <= cal_prev_nxt;
         cal_start_r <= cal_start_nxt;
         cal_busy_r <= cal_busy_nxt;
      end
   end

   assign dist_released = (sync_r == OPC_SYNC_FREE);
   assign dist_hold = hold_r;
   assign cal_start = cal_start_r;
   assign cal_busy = cal_busy_r;
endmodule
